// [hw/bus_timing_pkg.sv]
package bus_timing_pkg;

  localparam int addr_w = 24;
  localparam int data_w = 16;
  localparam int pin_sync_w = data_w + 1;

  // wishbone register map, byte addresses
  localparam logic [3:0] off_timing_low = 4'h0;
  localparam logic [3:0] off_timing_high = 4'h4;
  localparam logic [3:0] off_status = 4'h8;

  // bus_timing_low fields
  localparam int bit_latch_pulse_wide = 0;
  localparam int bit_write_hold_extend = 1;
  localparam int bit_write_pulse_wide = 2;
  localparam int lsb_code_len_short = 3;
  localparam int lsb_code_len_latched = 5;
  localparam int bit_bus_8bit = 7;
  // bus_timing_high fields
  localparam int lsb_read_len_short = 0;
  localparam int lsb_read_len_latched = 2;
  localparam int lsb_write_len_short = 4;
  localparam int lsb_write_len_latched = 6;
  // status fields
  localparam int bit_busy = 0;
  localparam int bit_timing_invalid = 1;
  localparam int bit_burst_open = 2;

  // extended hold preset, slowest cycle lengths
  localparam logic [7:0] rst_timing_low = 8'h7a;
  localparam logic [7:0] rst_timing_high = 8'hff;

  // bus timing is counted in half bus clocks, the base lengths in whole clocks
  localparam logic [4:0] half_none = 5'h00;
  localparam logic [4:0] half_one = 5'h01;
  localparam logic [4:0] half_latch_wide = 5'h03;
  localparam logic [4:0] half_write_narrow = 5'h02;
  localparam logic [4:0] half_write_wide = 5'h04;
  localparam logic [4:0] half_hold_ext = 5'h02;
  localparam logic [4:0] half_code_wait = 5'h04;
  localparam logic [4:0] half_read_wait_less = 5'h02;
  localparam logic [2:0] base_short_read = 3'h1;
  localparam logic [2:0] base_full_cycle = 3'h2;

  typedef enum logic [1:0] {kind_code, kind_read, kind_write} cycle_kind_t;

  typedef struct packed {
    logic valid;
    cycle_kind_t kind;
    logic latch;
    logic wide;
    logic burst;
    logic [1:0] be;
    logic [addr_w-1:0] addr;
    logic [data_w-1:0] wdata;
  } core_req_t;

  typedef struct packed {
    logic done;
    logic [data_w-1:0] rdata;
  } core_rsp_t;

endpackage

// [hw/pin_sync.sv]
`timescale 1ns/1ps
module pin_sync import bus_timing_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [pin_sync_w-1:0] d,
  output logic [pin_sync_w-1:0] q
);
  logic [pin_sync_w-1:0] meta;

  // first stage is read by the second stage only
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else if (ce) begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// [hw/bus_cycle_timing.sv]
// Contract
// RULE_01: short read strobe lasts one to four clocks
// RULE_02: latched read strobe is total minus latch minus half
// RULE_03: write strobes last one or two clocks
// RULE_04: latched write address setup from total, strobe, hold
// RULE_05: short write address setup from total, strobe, hold
// RULE_06: write data held zero or one clock
// RULE_07: latch end to write strobe gap computed
// RULE_08: latched write data setup one half less
// RULE_09: short write data setup equals address setup
// RULE_10: wait stretches strobe at per-kind sample point
// RULE_11: one-clock reads cannot be stretched
// RULE_12: burst fetch keeps fetch strobe low, low address advances
// RULE_13: partner sees A0 rise for second-byte wait
// RULE_14: extended write hold is the preset setting
// RULE_15: bad timing combinations are flagged and clamped
// RULE_16: latch pulse half or one and half clocks
// RULE_17: split read: latched first byte, short second byte
// RULE_18: everything counted in half clocks of bus clock
`timescale 1ns/1ps
module bus_cycle_timing import bus_timing_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire core_req_t core_req,
  output logic core_ready,
  output core_rsp_t core_rsp,
  output logic bus_reference_clock_out,
  output logic addr_latch_strobe,
  output logic [addr_w-1:0] addr_out,
  output logic [data_w-1:0] data_o,
  output logic data_oe,
  input wire logic [data_w-1:0] data_i,
  output logic read_strobe_n,
  output logic write_strobe_low_byte_n,
  output logic write_strobe_high_byte_n,
  output logic program_fetch_strobe_n,
  input wire logic wait_in
);
  typedef enum logic [2:0] {st_idle, st_latch, st_gap, st_strobe, st_hold} phase_t;
  typedef enum logic [1:0] {cap_none, cap_full, cap_low, cap_high} capture_t;

  function automatic logic [4:0] len_halfs(input logic [1:0] f, input logic [2:0] base);
    return {({2'h0, f} + {1'h0, base}), 1'b0};
  endfunction

  // what is left of a cycle after the used phases; never below one half
  function automatic logic [4:0] halves_left(input logic [4:0] total, input logic [4:0] used);
    return (total > used) ? total - used : half_one;
  endfunction

  function automatic logic [2:0] first_phase(input logic [4:0] lat, input logic [4:0] gap);
    return (lat != half_none) ? st_latch : (gap != half_none) ? st_gap : st_strobe;
  endfunction

  logic [7:0] bus_timing_low, bus_timing_high;
  logic [pin_sync_w-1:0] sync_q;
  logic wait_s;
  logic [data_w-1:0] data_s;
  phase_t phase, next_phase;
  logic [4:0] cnt, next_cnt;
  logic [4:0] lat_len, gap_len, str_len, hold_len, wait_pt, cur_len;
  logic [4:0] n_lat, n_gap, n_str, n_hold, n_wait;
  logic wait_en, n_wait_en, split, n_split, accept, last, stall, finish, second;
  capture_t cap_code, cap_d1, cap_d2;
  logic done_d1, done_d2;
  logic burst_open, next_burst_open, cont;
  cycle_kind_t kind, k;
  logic [1:0] be, b;
  logic wide;
  logic [data_w-1:0] wdata;
  logic timing_invalid;

  pin_sync u_pin_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .d({wait_in, data_i}),
    .q(sync_q)
  );
  assign wait_s = sync_q[data_w];
  assign data_s = sync_q[data_w-1:0];

  // configuration fields
  logic lpw, whe, wpw, bus8;
  logic [4:0] ale_h, v8_h, v11_h;
  logic [4:0] cl_s, cl_a, rl_s, rl_a, wl_s, wl_a;
  assign lpw = bus_timing_low[bit_latch_pulse_wide];
  assign whe = bus_timing_low[bit_write_hold_extend];
  assign wpw = bus_timing_low[bit_write_pulse_wide];
  assign bus8 = bus_timing_low[bit_bus_8bit];
  assign ale_h = lpw ? half_latch_wide : half_one; // RULE_16
  assign v8_h = wpw ? half_write_wide : half_write_narrow; // RULE_03
  assign v11_h = whe ? half_hold_ext : half_none; // RULE_06
  assign cl_s = len_halfs(bus_timing_low[lsb_code_len_short +: 2], base_short_read);
  assign cl_a = len_halfs(bus_timing_low[lsb_code_len_latched +: 2], base_full_cycle);
  assign rl_s = len_halfs(bus_timing_high[lsb_read_len_short +: 2], base_short_read); // RULE_01
  assign rl_a = len_halfs(bus_timing_high[lsb_read_len_latched +: 2], base_full_cycle);
  assign wl_s = len_halfs(bus_timing_high[lsb_write_len_short +: 2], base_full_cycle);
  assign wl_a = len_halfs(bus_timing_high[lsb_write_len_latched +: 2], base_full_cycle);

  // burst continues only while the upper address stays put
  assign cont = burst_open && core_req.kind == kind_code && core_req.burst &&
                core_req.addr[addr_w-1:4] == addr_out[addr_w-1:4]; // RULE_12

  // phase lengths for the request on offer
  always_comb begin
    n_lat = half_none;
    n_gap = half_none;
    n_str = half_one;
    n_hold = half_none;
    n_split = 1'b0;
    case (core_req.kind)
      kind_code: begin
        if (cont) begin
          n_str = cl_s; // RULE_12
        end else if (core_req.latch) begin
          n_lat = ale_h;
          n_gap = half_one;
          n_str = halves_left(cl_a, ale_h + half_one);
        end else begin
          // an open burst needs a half with the fetch strobe high
          n_gap = burst_open ? half_one : half_none;
          n_str = cl_s;
        end
        n_wait_en = n_str >= half_code_wait; // RULE_10
        n_wait = half_code_wait - half_one;
      end
      kind_write: begin
        n_str = v8_h; // RULE_03
        n_hold = v11_h; // RULE_06
        if (core_req.latch) begin
          n_lat = ale_h;
          n_gap = halves_left(wl_a, v8_h + v11_h + ale_h); // RULE_04 RULE_07 RULE_15
        end else begin
          n_gap = halves_left(wl_s, v8_h + v11_h); // RULE_05 RULE_09 RULE_15
        end
        n_split = bus8 && core_req.wide;
        n_wait_en = 1'b1; // RULE_10
        n_wait = v8_h - half_one;
      end
      default: begin
        if (core_req.latch) begin
          n_lat = ale_h;
          n_gap = half_one;
          n_str = halves_left(rl_a, ale_h + half_one); // RULE_02 RULE_15
        end else begin
          n_str = rl_s; // RULE_01
        end
        n_split = bus8 && core_req.wide; // RULE_17
        n_wait_en = n_str > half_read_wait_less; // RULE_11
        n_wait = n_str - half_read_wait_less - half_one; // RULE_10
      end
    endcase
  end

  always_comb begin
    case (phase)
      st_latch: cur_len = lat_len;
      st_gap: cur_len = gap_len;
      st_strobe: cur_len = str_len;
      st_hold: cur_len = hold_len;
      default: cur_len = half_one;
    endcase
  end

  assign last = cnt == cur_len - half_one;
  assign stall = phase == st_strobe && wait_en && cnt == wait_pt && wait_s; // RULE_10
  assign accept = core_req.valid && core_ready;
  // second byte of a split transfer begins here, never at a latch to gap step
  assign second = split && (kind != kind_write ? phase == st_strobe && last && !stall :
                  (phase == st_strobe || phase == st_hold) &&
                  (next_phase == st_latch || next_phase == st_gap)); // RULE_17

  always_comb begin
    cap_code = cap_none;
    if (phase == st_strobe && last && !stall && kind != kind_write) begin
      cap_code = !bus8 ? cap_full : (wide && !split) ? cap_high : cap_low;
    end
  end

  // one clk_sys cycle is one half of the bus clock
  always_comb begin
    next_phase = phase;
    next_cnt = cnt + half_one; // RULE_18
    finish = 1'b0;
    case (phase)
      st_idle: begin
        next_cnt = half_none;
        if (accept) begin
          next_phase = phase_t'(first_phase(n_lat, n_gap));
        end
      end
      st_latch, st_gap: begin
        if (last) begin
          next_cnt = half_none;
          next_phase = (phase == st_latch && gap_len != half_none) ? st_gap : st_strobe;
        end
      end
      st_strobe: begin
        if (stall) begin
          next_cnt = cnt;
        end else if (last) begin
          next_cnt = half_none;
          if (split && kind != kind_write) begin
            next_phase = st_strobe; // RULE_17
          end else if (hold_len != half_none) begin
            next_phase = st_hold;
          end else if (split) begin
            next_phase = phase_t'(first_phase(lat_len, gap_len));
          end else begin
            next_phase = st_idle;
            finish = 1'b1;
          end
        end
      end
      st_hold: begin
        if (last) begin
          next_cnt = half_none;
          next_phase = split ? phase_t'(first_phase(lat_len, gap_len)) : st_idle;
          finish = !split;
        end
      end
      default: begin
        next_phase = st_idle;
        next_cnt = half_none;
      end
    endcase
  end

  always_comb begin
    next_burst_open = burst_open;
    if (accept) begin
      next_burst_open = core_req.kind == kind_code && core_req.burst; // RULE_12
    end
  end

  assign k = accept ? core_req.kind : kind;
  assign b = accept ? core_req.be : be;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus_timing_low <= rst_timing_low; // RULE_14
      bus_timing_high <= rst_timing_high;
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      timing_invalid <= 1'b0;
    end else if (ce) begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]) begin
        if (wb_adr_i == off_timing_low) begin
          bus_timing_low <= wb_dat_i[7:0];
        end
        if (wb_adr_i == off_timing_high) begin
          bus_timing_high <= wb_dat_i[7:0];
        end
      end
      wb_dat_o <= '0;
      if (wb_adr_i == off_timing_low) begin
        wb_dat_o[7:0] <= bus_timing_low;
      end
      if (wb_adr_i == off_timing_high) begin
        wb_dat_o[7:0] <= bus_timing_high;
      end
      if (wb_adr_i == off_status) begin
        wb_dat_o[bit_busy] <= phase != st_idle;
        wb_dat_o[bit_timing_invalid] <= timing_invalid;
        wb_dat_o[bit_burst_open] <= burst_open;
      end
      timing_invalid <= wl_a <= v8_h + v11_h + ale_h || wl_s <= v8_h + v11_h ||
                        rl_a <= ale_h + half_one || cl_a <= ale_h + half_one; // RULE_15
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase <= st_idle;
      cnt <= half_none;
      lat_len <= half_none;
      gap_len <= half_none;
      str_len <= half_one;
      hold_len <= half_none;
      wait_pt <= half_none;
      wait_en <= 1'b0;
      split <= 1'b0;
      kind <= kind_code;
      be <= 2'h0;
      wide <= 1'b0;
      wdata <= '0;
      burst_open <= 1'b0;
    end else if (ce) begin
      phase <= next_phase;
      cnt <= next_cnt;
      burst_open <= next_burst_open;
      if (accept) begin
        lat_len <= n_lat;
        gap_len <= n_gap;
        str_len <= n_str;
        hold_len <= n_hold;
        wait_pt <= n_wait;
        wait_en <= n_wait_en;
        split <= n_split;
        kind <= core_req.kind;
        be <= bus8 ? 2'h1 : core_req.be;
        wide <= core_req.wide;
        wdata <= core_req.wdata;
      end else if (second) begin
        if (kind != kind_write) begin
          // second byte runs on the short read timing
          str_len <= rl_s; // RULE_17
          wait_en <= rl_s > half_read_wait_less; // RULE_11
          wait_pt <= rl_s - half_read_wait_less - half_one;
        end
        split <= 1'b0;
      end
    end
  end

  // pins follow the next phase so that every output is a flop
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus_reference_clock_out <= 1'b0;
      core_ready <= 1'b0;
      core_rsp <= '0;
      addr_latch_strobe <= 1'b0;
      addr_out <= '0;
      data_o <= '0;
      data_oe <= 1'b0;
      read_strobe_n <= 1'b1;
      write_strobe_low_byte_n <= 1'b1;
      write_strobe_high_byte_n <= 1'b1;
      program_fetch_strobe_n <= 1'b1;
      cap_d1 <= cap_none;
      cap_d2 <= cap_none;
      done_d1 <= 1'b0;
      done_d2 <= 1'b0;
    end else if (ce) begin
      bus_reference_clock_out <= !bus_reference_clock_out; // RULE_18
      // taken only where the bus clock is about to rise
      core_ready <= next_phase == st_idle && bus_reference_clock_out;
      addr_latch_strobe <= next_phase == st_latch; // RULE_16
      read_strobe_n <= !(k == kind_read && next_phase == st_strobe); // RULE_01 RULE_02
      write_strobe_low_byte_n <= !(k == kind_write && next_phase == st_strobe && b[0]);
      write_strobe_high_byte_n <= !(k == kind_write && next_phase == st_strobe && b[1]);
      program_fetch_strobe_n <= !(k == kind_code && next_phase == st_strobe ||
                                  next_phase == st_idle && next_burst_open); // RULE_12
      // latched writes drive data one half after the latch pulse ends
      data_oe <= k == kind_write && (next_phase == st_strobe || next_phase == st_hold ||
                 next_phase == st_gap && ((accept ? n_lat : lat_len) == half_none ||
                 next_cnt != half_none)); // RULE_06 RULE_08 RULE_09
      if (accept) begin
        addr_out <= core_req.addr;
        if (bus8 && core_req.wide) begin
          addr_out[0] <= 1'b0;
        end
        data_o <= core_req.wdata;
      end else if (second) begin
        addr_out[0] <= 1'b1; // RULE_13
        data_o[7:0] <= wdata[15:8];
      end
      // data of the last strobe cycle leaves the synchroniser two clocks on,
      // so capture and done wait for it; a one clock strobe stays readable
      cap_d1 <= cap_code;
      cap_d2 <= cap_d1;
      done_d1 <= finish;
      done_d2 <= done_d1;
      core_rsp.done <= done_d2;
      case (cap_d2)
        cap_full: core_rsp.rdata <= data_s;
        cap_low: core_rsp.rdata <= {8'h00, data_s[7:0]};
        cap_high: core_rsp.rdata[15:8] <= data_s[7:0];
        default: ;
      endcase
    end
  end
endmodule

// [test/bus_cycle_timing_properties.sv]
`timescale 1ns/1ps
module bus_cycle_timing_properties import bus_timing_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire core_rsp_t core_rsp,
  input wire logic bus_reference_clock_out,
  input wire logic addr_latch_strobe,
  input wire logic data_oe,
  input wire logic read_strobe_n,
  input wire logic write_strobe_low_byte_n
);
  logic [7:0] lo;
  logic [7:0] hi;
  logic wr_take;
  assign wr_take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  // shadow of the timing registers, rebuilt from bus writes alone
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lo <= rst_timing_low;
      hi <= rst_timing_high;
    end else if (wr_take && wb_adr_i == off_timing_low) begin
      lo <= wb_dat_i[7:0];
    end else if (wr_take && wb_adr_i == off_timing_high) begin
      hi <= wb_dat_i[7:0];
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  ack_after_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  done_pulse_a: assert property (core_rsp.done |=> !core_rsp.done) else $error("done too long");
  write_narrow_a: assert property (
    $fell(write_strobe_low_byte_n) && !lo[bit_write_pulse_wide]
    |-> ##1 !write_strobe_low_byte_n ##1 write_strobe_low_byte_n) else $error("strobe not 2");
  write_wide_a: assert property (
    $fell(write_strobe_low_byte_n) && lo[bit_write_pulse_wide]
    |-> !write_strobe_low_byte_n [*4] ##1 write_strobe_low_byte_n) else $error("strobe not 4");
  latch_narrow_a: assert property (
    $rose(addr_latch_strobe) && !lo[bit_latch_pulse_wide] |=> !addr_latch_strobe)
    else $error("latch not 1");
  latch_wide_a: assert property (
    $rose(addr_latch_strobe) && lo[bit_latch_pulse_wide]
    |-> addr_latch_strobe [*3] ##1 !addr_latch_strobe) else $error("latch not 3");
  hold_extend_a: assert property (
    $rose(write_strobe_low_byte_n) && lo[bit_write_hold_extend] |-> data_oe [*2])
    else $error("hold short");
  clock_divide_a: assert property (
    ce |=> bus_reference_clock_out != $past(bus_reference_clock_out))
    else $error("bus clock stuck");
  read_unstretched_a: assert property (
    $fell(read_strobe_n) && !$past(addr_latch_strobe, 2) && hi[1:0] == 2'h0
    |-> ##1 !read_strobe_n ##1 read_strobe_n) else $error("short read stretched");
  ce_freeze_a: assert property (!ce |=> $stable(bus_reference_clock_out))
    else $error("bus clock ran while frozen");
endmodule

bind bus_cycle_timing bus_cycle_timing_properties u_props (.clk_sys(clk_sys), .rst_n(rst_n),
  .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .core_rsp(core_rsp),
  .bus_reference_clock_out(bus_reference_clock_out), .addr_latch_strobe(addr_latch_strobe),
  .data_oe(data_oe), .read_strobe_n(read_strobe_n),
  .write_strobe_low_byte_n(write_strobe_low_byte_n));

// [test/ext_bus_model.sv]
`timescale 1ns/1ps
module ext_bus_model import bus_timing_pkg::*; (
  input wire logic clk_sys,
  input wire logic [addr_w-1:0] addr_out,
  input wire logic read_strobe_n,
  input wire logic program_fetch_strobe_n,
  input wire logic [3:0] stall,
  output logic [data_w-1:0] data_i,
  output logic wait_in
);
  logic [data_w-1:0] junk = 16'h0f0f;
  logic [3:0] left = 4'h0;
  logic rd_d = 1'b1;
  logic a0_d = 1'b0;
  // a released bus never shows the last value
  assign data_i = (!read_strobe_n || !program_fetch_strobe_n) ?
    {~addr_out[7:0], addr_out[7:0]} : junk;
  assign wait_in = (left != 4'h0);
  always @(posedge clk_sys) begin
    rd_d <= read_strobe_n;
    a0_d <= addr_out[0];
    junk <= ~junk ^ 16'h0001;
    if (rd_d && !read_strobe_n) begin
      left <= stall;
    end else if (!read_strobe_n && addr_out[0] && !a0_d) begin
      left <= stall;
    end else if (left != 4'h0) begin
      left <= left - 4'h1;
    end
  end
endmodule

// [test/bus_cycle_timing_tb_top.sv]
`timescale 1ns/1ps
module bus_cycle_timing_tb_top import bus_timing_pkg::*;;
  logic clk_sys = 1'b0, rst_n = 1'b0, ce = 1'b1, clr = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0, stall = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  core_req_t core_req = '0;
  core_rsp_t core_rsp;
  logic core_ready, bclk, ale, data_oe, rd_n, wrl_n, wrh_n, pf_n, wait_in;
  logic rd_d = 1'b1, pf_d = 1'b1, seen_wr = 1'b0;
  logic [addr_w-1:0] addr_out;
  logic [data_w-1:0] data_o, data_i, wd;
  int errors = 0, samples_checked = 0, cycles = 0;
  // 0 read low, 1 write low, 2 latch, 3 before write, 4 data before write,
  // 5 data after write, 6 read rises, 7 fetch rises (never cleared)
  int n [8];

  bus_cycle_timing dut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .core_req(core_req),
    .core_ready(core_ready), .core_rsp(core_rsp), .bus_reference_clock_out(bclk),
    .addr_latch_strobe(ale), .addr_out(addr_out), .data_o(data_o), .data_oe(data_oe),
    .data_i(data_i), .read_strobe_n(rd_n), .write_strobe_low_byte_n(wrl_n),
    .write_strobe_high_byte_n(wrh_n), .program_fetch_strobe_n(pf_n), .wait_in(wait_in));
  ext_bus_model mem (.clk_sys(clk_sys), .addr_out(addr_out), .read_strobe_n(rd_n),
    .program_fetch_strobe_n(pf_n), .stall(stall), .data_i(data_i), .wait_in(wait_in));

  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles > 20000) begin
      errors++;
      tally_and_finish();
    end
    if (clr) begin
      for (int i = 0; i < 7; i++) n[i] = 0;
      seen_wr = 1'b0;
    end
    if (data_oe && wrl_n && wrh_n && !seen_wr) n[4]++;
    if (!rd_n) n[0]++;
    if (ale) n[2]++;
    if (rd_n && !rd_d) n[6]++;
    if (pf_n && !pf_d) n[7]++;
    if (!wrl_n || !wrh_n) begin
      n[1]++;
      seen_wr = 1'b1;
      wd = data_o;
    end else if (!seen_wr) begin
      n[3]++;
    end else if (data_oe) begin
      n[5]++;
    end
    rd_d = rd_n;
    pf_d = pf_n;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [3:0] a, input logic [7:0] d,
                    output logic [31:0] q);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h0, d};
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic cfg(input logic [7:0] l, input logic [7:0] h);
    logic [31:0] q;
    wb(1'b1, off_timing_low, l, q);
    wb(1'b1, off_timing_high, h, q);
  endtask
  task automatic req(input cycle_kind_t k, input logic lat, input logic wide, input logic bst,
                     input logic [23:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    core_req <= '{1'b1, k, lat, wide, bst, 2'h3, a, d};
    do @(posedge clk_sys); while (core_ready !== 1'b1);
    core_req.valid <= 1'b0;
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
    while (core_rsp.done !== 1'b1) @(posedge clk_sys);
    // let the closing edge settle before counts are read
    #1;
  endtask

  task automatic t_regs();
    logic [31:0] q;
    wb(1'b0, off_timing_low, 8'h00, q);
    chk(q, 32'h7a);
    wb(1'b0, off_timing_high, 8'h00, q);
    chk(q, 32'hff);
    wb(1'b1, 4'hc, 8'h55, q);
    wb(1'b0, 4'hc, 8'h00, q);
    chk(q, 32'h0);
    $display("regs test done");
  endtask
  task automatic t_read();
    int e;
    logic [31:0] q;
    for (int rs = 0; rs < 4; rs++) begin
      cfg(8'h7a, {6'h3f, rs[1:0]});
      req(kind_read, 1'b0, 1'b0, 1'b0, 24'h000120 + rs, 16'h0);
      chk(n[0], 2 * (rs + 1));
      chk(core_rsp.rdata, {~rs[7:0] & 8'hdf, 8'h20 | rs[7:0]});
    end
    for (int rl = 0; rl < 4; rl++) begin
      for (int w = 0; w < 2; w++) begin
        cfg({7'h3d, w[0]}, {4'hf, rl[1:0], 2'h3});
        e = 2 * (rl + 2) - (w ? 3 : 1) - 1;
        if (e < 1) begin
          e = 1;
          wb(1'b0, off_status, 8'h00, q);
          chk(q[bit_timing_invalid], 1'b1);
        end
        req(kind_read, 1'b1, 1'b0, 1'b0, 24'h000200, 16'h0);
        chk(n[2], w ? 3 : 1);
        chk(n[0], e);
      end
    end
    $display("read test done");
  endtask
  task automatic t_write();
    int s;
    for (int i = 0; i < 8; i++) begin
      cfg({5'h0f, i[1], i[0], 1'b0}, 8'hff);
      s = 10 - (i[1] ? 4 : 2) - (i[0] ? 2 : 0);
      req(kind_write, i[2], 1'b0, 1'b0, 24'h000300, 16'hc3a5 + i);
      chk(n[1], i[1] ? 4 : 2);
      chk(n[5], i[0] ? 2 : 0);
      chk(n[3], s);
      chk(n[4], i[2] ? s - 2 : s);
      chk(wd, 16'hc3a5 + i);
      if (i[2]) chk(n[3] - n[2], s - 1);
    end
    $display("write test done");
  endtask
  task automatic t_wait();
    cfg(8'h7a, 8'hff);
    stall <= 4'h4;
    req(kind_read, 1'b0, 1'b0, 1'b0, 24'h000400, 16'h0);
    chk(n[0] > 8, 1'b1);
    cfg(8'h7a, 8'hfc);
    req(kind_read, 1'b0, 1'b0, 1'b0, 24'h000400, 16'h0);
    chk(n[0], 2);
    cfg(8'hfa, 8'hff);
    req(kind_read, 1'b1, 1'b1, 1'b0, 24'h000340, 16'h0);
    stall <= 4'h0;
    chk(n[6], 1);
    chk(n[2], 1);
    chk(core_rsp.rdata, 16'h4140);
    $display("wait test done");
  endtask
  task automatic t_burst();
    int p;
    cfg(8'h7a, 8'hff);
    req(kind_code, 1'b0, 1'b0, 1'b1, 24'h000500, 16'h0);
    p = n[7];
    req(kind_code, 1'b0, 1'b0, 1'b1, 24'h000502, 16'h0);
    chk(n[7] - p, 0);
    chk(core_rsp.rdata, 16'hfd02);
    p = n[7];
    req(kind_read, 1'b0, 1'b0, 1'b0, 24'h000600, 16'h0);
    chk(n[7] - p, 1);
    $display("burst test done");
  endtask

  task automatic t_freeze();
    logic b;
    @(posedge clk_sys);
    ce <= 1'b0;
    @(posedge clk_sys);
    b = bclk;
    repeat (3) @(posedge clk_sys);
    chk(bclk, b);
    ce <= 1'b1;
    $display("freeze test done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs();
    t_freeze();
    t_read();
    t_write();
    t_wait();
    t_burst();
    tally_and_finish();
  end
endmodule
